/* rtl/rtcal_top.sv */
// What this block does
// RL1 - Positive trim adds four ticks each minute
// RL2 - Negative trim removes four ticks each minute
// RL3 - Config register reset only by power-on
// RL4 - Run enable writable only when unlocked
// RL5 - Half-second flag read-only, cleared by seconds write
// RL6 - Output select picks seconds clock or alarm
// RL7 - Pin driven only with output enable
// RL8 - Year holds two BCD digits
// RL9 - Year writes need unlock
// RL10 - Month tens bit 12, ones 11-8
// RL11 - Day tens bits 5-4, ones 3-0
// RL12 - Weekday in bits 10-8, 0 to 6
// RL13 - Hour tens 5-4, ones 3-0
// RL14 - Minute tens 14-12, ones 11-8
// RL15 - Second tens 6-4, ones 3-0
// RL16 - Date, hour, alarm time writes need unlock
// RL17 - Unimplemented bits read zero, ignore writes
// RL18 - Alarm mask selects alarm period
// RL19 - Repeat count decrements, last alarm disables
// RL20 - Forever mode rolls count to FFh
// RL21 - Alarm event pulse; output toggles each alarm
// RL22 - Time counts as BCD calendar
// RL23 - Time values have no reset
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/10ps
`include "rtcal_cfg.svh"
module rtcal_top
    import rtcal_pkg::*;
#(
    parameter int TICKS_PER_HALF = 16384
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic por_n,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic clock_out,
    output logic alarm_event,
    output logic parallel_port_input_level_select
);
    // ==========================================
    // Helpers
    function automatic logic [3:0] bcd_inc(input logic [3:0] d);
        bcd_inc = (d == 4'h9) ? 4'h0 : 4'(d + 4'h1);
    endfunction
    function automatic logic [7:0] month_last(input logic [7:0] m, input logic [7:0] y);
        logic leap;
        leap = (y[4] == 1'b0) ? (y[1:0] == 2'b00 && (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8))
                              : (y[3:0] == 4'h2 || y[3:0] == 4'h6);
        if (m == 8'h02) month_last = leap ? 8'h29 : 8'h28; // [RL22]
        else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) month_last = 8'h30;
        else month_last = 8'h31;
    endfunction
    function automatic logic [15:0] wmerge(input logic [15:0] old, input logic [31:0] d,
                                           input logic [3:0] strb, input logic [15:0] mask);
        logic [15:0] n;
        n = old;
        if (strb[0]) n[7:0] = d[7:0];
        if (strb[1]) n[15:8] = d[15:8];
        wmerge = n & mask; // [RL17]
    endfunction

    // ==========================================
    // AXI4-Lite write channel
    logic aw_held, w_held;
    logic [7:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_go;
    assign s_axi_awready = !aw_held && !s_axi_bvalid;
    assign s_axi_wready = !w_held && !s_axi_bvalid;
    assign s_axi_bresp = 2'b00;
    assign wr_go = aw_held && w_held && !s_axi_bvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            s_axi_bvalid <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h0;
            w_strb <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held <= 1'b1;
                aw_addr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held <= 1'b1;
                w_data <= s_axi_wdata;
                w_strb <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                s_axi_bvalid <= 1'b1;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ==========================================
    // Register state
    rtcal_word_t cal_config, pad_config, alarm_cfg;
    rtcal_word_t year_value, month_day_value, weekday_hour_value, minute_second_value;
    rtcal_word_t alm_md, alm_wh, alm_ms;
    logic half_second_flag;
    logic rtc_write_unlock, clock_run_enable;
    assign rtc_write_unlock = cal_config[`RTCAL_CAL_UNLOCK_BIT];
    assign clock_run_enable = cal_config[`RTCAL_CAL_RUN_BIT];
    logic wr_cal, wr_pad, wr_alm, wr_yr, wr_md, wr_wh, wr_ms, wr_amd, wr_awh, wr_ams;
    always_comb begin
        {wr_cal, wr_pad, wr_alm, wr_yr, wr_md,
         wr_wh, wr_ms, wr_amd, wr_awh, wr_ams} = 10'h000;
        if (!wr_go) begin
        end else if (aw_addr == `RTCAL_OFS_CAL_CONFIG) wr_cal = 1'b1;
        else if (aw_addr == `RTCAL_OFS_PAD_CONFIG) wr_pad = 1'b1;
        else if (aw_addr == `RTCAL_OFS_ALARM_CFG) wr_alm = 1'b1;
        else if (aw_addr == `RTCAL_OFS_YEAR) wr_yr = rtc_write_unlock; // [RL9]
        else if (aw_addr == `RTCAL_OFS_MONTH_DAY) wr_md = rtc_write_unlock; // [RL16]
        else if (aw_addr == `RTCAL_OFS_WEEKDAY_HOUR) wr_wh = rtc_write_unlock; // [RL16]
        else if (aw_addr == `RTCAL_OFS_MINUTE_SECOND) wr_ms = 1'b1;
        else if (aw_addr == `RTCAL_OFS_ALM_MONTH_DAY) wr_amd = rtc_write_unlock; // [RL16]
        else if (aw_addr == `RTCAL_OFS_ALM_WEEKDAY_HOUR) wr_awh = rtc_write_unlock; // [RL16]
        else if (aw_addr == `RTCAL_OFS_ALM_MINUTE_SECOND) wr_ams = rtc_write_unlock; // [RL16]
    end

    // Calibration/config survives bus reset; only power-on clears it
    always_ff @(posedge aclk) begin
        if (!por_n) begin
            cal_config <= `RTCAL_RST_CAL_CONFIG; // [RL3]
        end else if (wr_cal) begin
            cal_config <= wmerge(cal_config, w_data, w_strb, `RTCAL_MASK_CAL_CONFIG);
            if (!rtc_write_unlock) begin
                cal_config[`RTCAL_CAL_RUN_BIT] <= clock_run_enable; // [RL4]
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pad_config <= `RTCAL_RST_PAD_CONFIG;
        end else if (wr_pad) begin
            pad_config <= wmerge(pad_config, w_data, w_strb, `RTCAL_MASK_PAD_CONFIG);
        end
    end
    assign parallel_port_input_level_select = pad_config[`RTCAL_PAD_LEVEL_BIT];

    // ==========================================
    // Tick generator
    rtcal_tick_if tick_bus();
    logic minute_mark;
    assign tick_bus.run = clock_run_enable;
    assign tick_bus.trim = cal_config[7:0];
    assign tick_bus.minute_mark = minute_mark;
    rtcal_tick_gen #(.TICKS_PER_HALF(TICKS_PER_HALF)) u_tick (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick_bus)
    );
    logic sec_tick;
    assign sec_tick = tick_bus.half_tick && half_second_flag;

    // ==========================================
    // Half-second flag
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            half_second_flag <= 1'b0;
        end else if (wr_ms && w_strb[0]) begin
            half_second_flag <= 1'b0; // [RL5]
        end else if (tick_bus.half_tick) begin
            half_second_flag <= !half_second_flag;
        end
    end

    // ==========================================
    // Calendar counting, values left unreset
    logic roll_s, roll_m, roll_h, roll_d, roll_mo;
    always_comb begin
        roll_s = sec_tick && minute_second_value[6:0] == 7'h59; // [RL15]
        roll_m = roll_s && minute_second_value[14:8] == 7'h59; // [RL14]
        roll_h = roll_m && weekday_hour_value[5:0] == 6'h23; // [RL13]
        roll_d = roll_h && {2'b00, month_day_value[5:0]} ==
                 month_last({3'b000, month_day_value[12:8]}, year_value[7:0]); // [RL11]
        roll_mo = roll_d && month_day_value[12:8] == 5'h12; // [RL10]
    end
    assign minute_mark = roll_s;
    always_ff @(posedge aclk) begin // [RL23]
        if (wr_ms) begin
            minute_second_value <= wmerge(minute_second_value, w_data, w_strb, `RTCAL_MASK_MINUTE_SECOND);
        end else if (sec_tick) begin
            if (minute_second_value[3:0] != 4'h9) begin
                minute_second_value[3:0] <= bcd_inc(minute_second_value[3:0]);
            end else begin
                minute_second_value[3:0] <= 4'h0;
                minute_second_value[6:4] <= roll_s ? 3'h0 : 3'(minute_second_value[6:4] + 3'h1);
                if (roll_s) begin
                    minute_second_value[11:8] <= bcd_inc(minute_second_value[11:8]);
                    if (minute_second_value[11:8] == 4'h9) begin
                        minute_second_value[14:12] <= roll_m ? 3'h0 : 3'(minute_second_value[14:12] + 3'h1);
                    end
                end
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (wr_wh) begin
            weekday_hour_value <= wmerge(weekday_hour_value, w_data, w_strb, `RTCAL_MASK_WEEKDAY_HOUR);
        end else if (roll_m) begin
            if (roll_h) begin
                weekday_hour_value[5:0] <= 6'h00;
                weekday_hour_value[10:8] <= (weekday_hour_value[10:8] == 3'h6) ? 3'h0 : 3'(weekday_hour_value[10:8] + 3'h1); // [RL12]
            end else if (weekday_hour_value[3:0] == 4'h9) begin
                weekday_hour_value[3:0] <= 4'h0;
                weekday_hour_value[5:4] <= 2'(weekday_hour_value[5:4] + 2'h1);
            end else begin
                weekday_hour_value[3:0] <= bcd_inc(weekday_hour_value[3:0]);
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (wr_md) begin
            month_day_value <= wmerge(month_day_value, w_data, w_strb, `RTCAL_MASK_MONTH_DAY);
        end else if (roll_h) begin
            if (roll_d) begin
                month_day_value[5:0] <= 6'h01;
                if (roll_mo) month_day_value[12:8] <= 5'h01;
                else if (month_day_value[11:8] == 4'h9) month_day_value[12:8] <= 5'h10;
                else month_day_value[11:8] <= 4'(month_day_value[11:8] + 4'h1);
            end else if (month_day_value[3:0] == 4'h9) begin
                month_day_value[3:0] <= 4'h0;
                month_day_value[5:4] <= 2'(month_day_value[5:4] + 2'h1);
            end else begin
                month_day_value[3:0] <= bcd_inc(month_day_value[3:0]);
            end
        end
    end
    always_ff @(posedge aclk) begin
        if (wr_yr) begin
            year_value <= wmerge(year_value, w_data, w_strb, `RTCAL_MASK_YEAR); // [RL8]
        end else if (roll_mo) begin
            year_value[3:0] <= bcd_inc(year_value[3:0]);
            if (year_value[3:0] == 4'h9) year_value[7:4] <= bcd_inc(year_value[7:4]);
        end
    end
    always_ff @(posedge aclk) begin
        if (wr_amd) alm_md <= wmerge(alm_md, w_data, w_strb, `RTCAL_MASK_MONTH_DAY);
        if (wr_awh) alm_wh <= wmerge(alm_wh, w_data, w_strb, `RTCAL_MASK_WEEKDAY_HOUR);
        if (wr_ams) alm_ms <= wmerge(alm_ms, w_data, w_strb, `RTCAL_MASK_MINUTE_SECOND);
    end

    // ==========================================
    // Alarm match and repeat
    logic match, ms_hit;
    always_comb begin
        match = 1'b0;
        ms_hit = sec_tick && minute_second_value == alm_ms;
        case (alarm_cfg[13:10]) // [RL18]
            4'h0: match = tick_bus.half_tick;
            4'h1: match = sec_tick;
            4'h2: match = sec_tick && minute_second_value[3:0] == alm_ms[3:0];
            4'h3: match = sec_tick && minute_second_value[6:0] == alm_ms[6:0];
            4'h4: match = sec_tick && minute_second_value[11:0] == alm_ms[11:0];
            4'h5: match = ms_hit;
            4'h6: match = ms_hit && weekday_hour_value[5:0] == alm_wh[5:0];
            4'h7: match = ms_hit && weekday_hour_value == alm_wh;
            4'h8: match = ms_hit && weekday_hour_value[5:0] == alm_wh[5:0] && month_day_value[5:0] == alm_md[5:0];
            4'h9: match = ms_hit && weekday_hour_value[5:0] == alm_wh[5:0]
                          && month_day_value == alm_md;
            default: match = 1'b0;
        endcase
    end
    logic fire;
    assign fire = match && alarm_cfg[`RTCAL_ALM_EN_BIT];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm_cfg <= `RTCAL_RST_ALARM_CFG;
        end else if (wr_alm) begin
            alarm_cfg <= wmerge(alarm_cfg, w_data, w_strb, `RTCAL_MASK_ALARM_CFG);
        end else if (fire) begin
            alarm_cfg[7:0] <= 8'(alarm_cfg[7:0] - 8'h01); // [RL19] [RL20]
            if (alarm_cfg[7:0] == 8'h00 && !alarm_cfg[`RTCAL_ALM_FOREVER_BIT]) begin
                alarm_cfg[`RTCAL_ALM_EN_BIT] <= 1'b0; // [RL19]
                alarm_cfg[7:0] <= 8'h00;
            end
        end
    end
    logic alarm_pulse;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm_event <= 1'b0;
            alarm_pulse <= 1'b0;
        end else begin
            alarm_event <= fire; // [RL21]
            if (fire) alarm_pulse <= !alarm_pulse; // [RL21]
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_out <= 1'b0;
        end else if (!cal_config[`RTCAL_CAL_OE_BIT]) begin
            clock_out <= 1'b0; // [RL7]
        end else begin
            clock_out <= pad_config[`RTCAL_PAD_SECSEL_BIT] ? half_second_flag : alarm_pulse; // [RL6]
        end
    end

    // ==========================================
    // AXI4-Lite read channel
    rtcal_word_t rd_word;
    logic rd_ok;
    always_comb begin
        rd_word = 16'h0000;
        rd_ok = 1'b1;
        if (s_axi_araddr == `RTCAL_OFS_CAL_CONFIG) begin
            rd_word = cal_config;
            rd_word[`RTCAL_CAL_HALF_SECOND_FLAG_BIT] = half_second_flag;
        end else if (s_axi_araddr == `RTCAL_OFS_PAD_CONFIG) rd_word = pad_config;
        else if (s_axi_araddr == `RTCAL_OFS_ALARM_CFG) rd_word = alarm_cfg;
        else if (s_axi_araddr == `RTCAL_OFS_YEAR) rd_word = year_value;
        else if (s_axi_araddr == `RTCAL_OFS_MONTH_DAY) rd_word = month_day_value;
        else if (s_axi_araddr == `RTCAL_OFS_WEEKDAY_HOUR) rd_word = weekday_hour_value;
        else if (s_axi_araddr == `RTCAL_OFS_MINUTE_SECOND) rd_word = minute_second_value;
        else if (s_axi_araddr == `RTCAL_OFS_ALM_MONTH_DAY) rd_word = alm_md;
        else if (s_axi_araddr == `RTCAL_OFS_ALM_WEEKDAY_HOUR) rd_word = alm_wh;
        else if (s_axi_araddr == `RTCAL_OFS_ALM_MINUTE_SECOND) rd_word = alm_ms;
        else rd_ok = 1'b0;
    end
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'b00;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {16'h0000, rd_word};
            s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
endmodule

/* rtl/rtcal_cfg.svh */
`ifndef RTCAL_CFG_SVH
`define RTCAL_CFG_SVH
// ==========================================
// Register offsets (byte addresses)
`define RTCAL_OFS_CAL_CONFIG 8'h00
`define RTCAL_OFS_PAD_CONFIG 8'h04
`define RTCAL_OFS_ALARM_CFG 8'h08
`define RTCAL_OFS_YEAR 8'h0C
`define RTCAL_OFS_MONTH_DAY 8'h10
`define RTCAL_OFS_WEEKDAY_HOUR 8'h14
`define RTCAL_OFS_MINUTE_SECOND 8'h18
`define RTCAL_OFS_ALM_MONTH_DAY 8'h1C
`define RTCAL_OFS_ALM_WEEKDAY_HOUR 8'h20
`define RTCAL_OFS_ALM_MINUTE_SECOND 8'h24
// ==========================================
// Field positions
`define RTCAL_CAL_RUN_BIT 15
`define RTCAL_CAL_UNLOCK_BIT 13
`define RTCAL_CAL_HALF_SECOND_FLAG_BIT 11
`define RTCAL_CAL_OE_BIT 10
`define RTCAL_PAD_SECSEL_BIT 1
`define RTCAL_PAD_LEVEL_BIT 0
`define RTCAL_ALM_EN_BIT 15
`define RTCAL_ALM_FOREVER_BIT 14
// ==========================================
// Writable masks (unimplemented bits read 0)
`define RTCAL_MASK_CAL_CONFIG 16'hA4FF
`define RTCAL_MASK_PAD_CONFIG 16'h0003
`define RTCAL_MASK_ALARM_CFG 16'hFFFF
`define RTCAL_MASK_YEAR 16'h00FF
`define RTCAL_MASK_MONTH_DAY 16'h1F3F
`define RTCAL_MASK_WEEKDAY_HOUR 16'h073F
`define RTCAL_MASK_MINUTE_SECOND 16'h7F7F
// ==========================================
// Reset values and timing
`define RTCAL_RST_CAL_CONFIG 16'h0000
`define RTCAL_RST_PAD_CONFIG 16'h0000
`define RTCAL_RST_ALARM_CFG 16'h0000
`define RTCAL_TICK_HZ 32768
`define RTCAL_CLK_HZ 10000000
`define RTCAL_CAL_STEP 4
`endif

/* rtl/rtcal_pkg.sv */
package rtcal_pkg;
    typedef enum logic [1:0] {RTCAL_ALM_IDLE, RTCAL_ALM_ARMED, RTCAL_ALM_HIT} rtcal_alm_e;
    typedef logic [15:0] rtcal_word_t;
endpackage

/* rtl/rtcal_tick_if.sv */
`timescale 1ns/10ps
interface rtcal_tick_if;
    logic run;
    logic [7:0] trim;
    logic minute_mark;
    logic half_tick;
    modport gen (input run, input trim, input minute_mark, output half_tick);
    modport user (output run, output trim, output minute_mark, input half_tick);
endinterface

/* rtl/rtcal_tick_gen.sv */
`timescale 1ns/10ps
`include "rtcal_cfg.svh"
module rtcal_tick_gen #(
    parameter int TICKS_PER_HALF = 16384
) (
    input wire logic aclk,
    input wire logic aresetn,
    rtcal_tick_if.gen tick
);
    // ==========================================
    // Half-second divider with per-minute trim
    initial begin
        if (TICKS_PER_HALF < 600) $error("TICKS_PER_HALF too small for trim range");
    end
    logic [31:0] count;
    logic [31:0] limit;
    logic signed [31:0] trim_ext;
    logic trim_pending;
    always_comb begin
        trim_ext = 32'($signed(tick.trim)) * `RTCAL_CAL_STEP;
        limit = 32'(TICKS_PER_HALF) - 32'h1;
        // Positive adds ticks, so the half period is longer
        if (trim_pending) begin
            limit = 32'($signed(limit) + trim_ext); // [RL1] [RL2]
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trim_pending <= 1'b0;
        end else if (tick.minute_mark) begin
            trim_pending <= 1'b1;
        end else if (tick.half_tick) begin
            trim_pending <= 1'b0;
        end
    end
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= 32'h0;
        end else if (!tick.run) begin
            count <= 32'h0;
        end else if (count >= limit) begin
            count <= 32'h0;
        end else begin
            count <= count + 32'h1;
        end
    end
    assign tick.half_tick = tick.run && (count >= limit);
endmodule

/* verification/rtcal_top_monitor.sv */
`timescale 1ns/10ps
`include "rtcal_cfg.svh"
module rtcal_top_monitor #(
    parameter int TICKS_PER_HALF = 16384
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    input wire logic clock_out,
    input wire logic alarm_event
);
    // ==========================================
    // Address of the read in flight
    logic [7:0] rd_addr;
    logic [15:0] rd_mask;
    always_ff @(posedge aclk) begin
        if (s_axi_arvalid && s_axi_arready) begin
            rd_addr <= s_axi_araddr;
        end
    end
    always_comb begin
        case (rd_addr[7:2])
            6'h00: rd_mask = 16'hACFF; // Writable bits plus the read-only half flag
            6'h01: rd_mask = `RTCAL_MASK_PAD_CONFIG;
            6'h02: rd_mask = `RTCAL_MASK_ALARM_CFG;
            6'h03: rd_mask = `RTCAL_MASK_YEAR;
            6'h04, 6'h07: rd_mask = `RTCAL_MASK_MONTH_DAY;
            6'h05, 6'h08: rd_mask = `RTCAL_MASK_WEEKDAY_HOUR;
            6'h06, 6'h09: rd_mask = `RTCAL_MASK_MINUTE_SECOND;
            default: rd_mask = 16'h0000;
        endcase
    end
    // ==========================================
    // Checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_unused_bits_zero: assert property (s_axi_rvalid |-> (s_axi_rdata & ~{16'h0000, rd_mask}) == 32'h0)
        else $error("unimplemented bits read nonzero");
    a_unmapped_err: assert property ((s_axi_rvalid && rd_addr[7:2] > 6'h09) |->
        (s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)) else $error("unmapped read not refused");
    a_year_bcd: assert property ((s_axi_rvalid && rd_addr == `RTCAL_OFS_YEAR) |->
        (s_axi_rdata[7:4] <= 4'h9 && s_axi_rdata[3:0] <= 4'h9)) else $error("year digit out of range");
    a_month_day_bcd: assert property ((s_axi_rvalid && rd_mask == `RTCAL_MASK_MONTH_DAY) |->
        (s_axi_rdata[11:8] <= 4'h9 && s_axi_rdata[3:0] <= 4'h9)) else $error("month or day out of range");
    a_weekday_digit_hour_bcd: assert property ((s_axi_rvalid && rd_mask == `RTCAL_MASK_WEEKDAY_HOUR) |->
        (s_axi_rdata[10:8] <= 3'h6 && s_axi_rdata[5:4] <= 2'h2 && s_axi_rdata[3:0] <= 4'h9))
        else $error("weekday or hour out of range");
    a_min_sec_bcd: assert property ((s_axi_rvalid && rd_mask == `RTCAL_MASK_MINUTE_SECOND) |->
        (s_axi_rdata[14:12] <= 3'h5 && s_axi_rdata[11:8] <= 4'h9 && s_axi_rdata[6:4] <= 3'h5
        && s_axi_rdata[3:0] <= 4'h9)) else $error("minute or second out of range");
    a_event_single: assert property (alarm_event |=> !alarm_event)
        else $error("alarm event longer than one cycle");
    a_reset_quiet: assert property ($rose(aresetn) |-> (!clock_out && !alarm_event))
        else $error("pin active after reset");
endmodule
bind rtcal_top rtcal_top_monitor #(.TICKS_PER_HALF(TICKS_PER_HALF)) i_monitor (.*);

/* verification/rtcal_top_tb.sv */
`timescale 1ns/10ps
`include "rtcal_cfg.svh"
module rtcal_top_tb;
    localparam int TPH = 600;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic por_n = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00;
    logic [7:0] s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic clock_out, alarm_event, parallel_port_input_level_select;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, d;
    int num_errors = 0;
    int samples_checked = 0;
    int cycles = 0, events = 0;
    rtcal_top #(.TICKS_PER_HALF(TPH)) i_dut (.*);
    initial begin
        forever #50 aclk = ~aclk;
    end
    always @(posedge aclk) begin
        cycles <= cycles + 1;
        if (alarm_event === 1'b1) begin
            events <= events + 1;
        end
        if (cycles == 40000) begin
            num_errors++;
            give_verdict();
        end
    end
    // ==========================================
    // Bus and compare helpers
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [3:0] s);
        logic aw_hit, w_hit, b_hit;
        @(posedge aclk);
        {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, 16'h0000, v, s};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do begin
            @(negedge aclk);
            {aw_hit, w_hit, b_hit} = {s_axi_awvalid & s_axi_awready, s_axi_wvalid & s_axi_wready, s_axi_bvalid};
            @(posedge aclk);
            if (aw_hit) s_axi_awvalid <= 1'b0;
            if (w_hit) s_axi_wvalid <= 1'b0;
        end while (b_hit !== 1'b1);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v, output logic [1:0] e);
        logic hit, fin;
        @(posedge aclk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do begin
            @(negedge aclk);
            {hit, fin, v, e} = {s_axi_arvalid & s_axi_arready, s_axi_rvalid, s_axi_rdata, s_axi_rresp};
            @(posedge aclk);
            if (hit) s_axi_arvalid <= 1'b0;
        end while (fin !== 1'b1);
        s_axi_rready <= 1'b0;
    endtask
    task automatic rchk(input logic [7:0] a, input logic [15:0] e, input logic [15:0] m);
        rd_reg(a, d, r);
        check($sformatf("reg %h", a), d & {16'h0000, m}, {16'h0000, e});
    endtask
    // ==========================================
    // Scenarios
    task automatic s_reset_map();
        rchk(`RTCAL_OFS_CAL_CONFIG, 16'h0000, 16'hFFFF);
        rchk(`RTCAL_OFS_ALARM_CFG, 16'h0000, 16'hFFFF);
        wr(8'h40, 16'hFFFF, 4'h3);
        rd_reg(8'h40, d, r);
        check("unmapped resp", {30'h0, r}, 32'h2);
        wr(`RTCAL_OFS_PAD_CONFIG, 16'hFFFD, 4'h3);
        rchk(`RTCAL_OFS_PAD_CONFIG, 16'h0001, 16'hFFFF);
        check("level select", {31'h0, parallel_port_input_level_select}, 32'h1);
        for (int m = 0; m < 10; m++) begin
            wr(`RTCAL_OFS_ALARM_CFG, {2'h0, m[3:0], 10'h3A5}, 4'h3);
            rchk(`RTCAL_OFS_ALARM_CFG, {2'h0, m[3:0], 10'h3A5}, 16'hFFFF);
        end
        wr(`RTCAL_OFS_ALARM_CFG, 16'h0000, 4'h3);
    endtask
    task automatic s_locks();
        wr(`RTCAL_OFS_CAL_CONFIG, 16'h8000, 4'h3);
        rchk(`RTCAL_OFS_CAL_CONFIG, 16'h0000, 16'hF7FF);
        wr(`RTCAL_OFS_CAL_CONFIG, 16'h2000, 4'h3);
        wr(`RTCAL_OFS_YEAR, 16'hFF23, 4'h3);
        rchk(`RTCAL_OFS_YEAR, 16'h0023, 16'hFFFF);
        wr(`RTCAL_OFS_MONTH_DAY, 16'hE931, 4'h3);
        rchk(`RTCAL_OFS_MONTH_DAY, 16'h0931, 16'hFFFF);
        wr(`RTCAL_OFS_CAL_CONFIG, 16'h0000, 4'h3);
        wr(`RTCAL_OFS_YEAR, 16'h0045, 4'h3);
        rchk(`RTCAL_OFS_YEAR, 16'h0023, 16'hFFFF);
        wr(`RTCAL_OFS_MONTH_DAY, 16'h0101, 4'h3);
        rchk(`RTCAL_OFS_MONTH_DAY, 16'h0931, 16'hFFFF);
        wr(`RTCAL_OFS_CAL_CONFIG, 16'h2000, 4'h3);
        wr(`RTCAL_OFS_CAL_CONFIG, 16'hA000, 4'h3);
        rchk(`RTCAL_OFS_CAL_CONFIG, 16'hA000, 16'hF7FF);
    endtask
    task automatic s_calendar();
        wr(`RTCAL_OFS_YEAR, 16'h0099, 4'h3);
        wr(`RTCAL_OFS_MONTH_DAY, 16'h1231, 4'h3);
        wr(`RTCAL_OFS_WEEKDAY_HOUR, 16'h0623, 4'h3);
        wr(`RTCAL_OFS_MINUTE_SECOND, 16'h5959, 4'h3);
        for (int i = 0; i < 500 && d[15:0] !== 16'h0000; i++) rd_reg(`RTCAL_OFS_MINUTE_SECOND, d, r);
        check("rolled seconds", d, 32'h0);
        rchk(`RTCAL_OFS_WEEKDAY_HOUR, 16'h0000, 16'hFFFF);
        rchk(`RTCAL_OFS_MONTH_DAY, 16'h0101, 16'hFFFF);
        rchk(`RTCAL_OFS_YEAR, 16'h0000, 16'hFFFF);
    endtask
    task automatic s_half_flag();
        d = 32'h0;
        for (int i = 0; i < 500 && d[11] !== 1'b1; i++) rd_reg(`RTCAL_OFS_CAL_CONFIG, d, r);
        check("half flag set", {31'h0, d[11]}, 32'h1);
        wr(`RTCAL_OFS_MINUTE_SECOND, 16'h0010, 4'h1);
        wr(`RTCAL_OFS_CAL_CONFIG, 16'hA800, 4'h3);
        rchk(`RTCAL_OFS_CAL_CONFIG, 16'hA000, 16'hFFFF);
    endtask
    task automatic s_clock_pin(input logic [15:0] cal, input logic [31:0] exp);
        logic seen;
        wr(`RTCAL_OFS_PAD_CONFIG, 16'h0002, 4'h3);
        wr(`RTCAL_OFS_CAL_CONFIG, cal, 4'h3);
        seen = 1'b0;
        repeat (3 * TPH) @(posedge aclk) if (clock_out === 1'b1) seen = 1'b1;
        check("seconds pin", {31'h0, seen}, exp);
    endtask
    task automatic s_alarm();
        int n;
        n = events;
        wr(`RTCAL_OFS_ALARM_CFG, 16'h8002, 4'h3);
        repeat (5 * TPH) @(posedge aclk);
        check("alarm count", events - n, 32'h3);
        rchk(`RTCAL_OFS_ALARM_CFG, 16'h0000, 16'hFFFF);
        wr(`RTCAL_OFS_ALARM_CFG, 16'hC400, 4'h3);
        do @(posedge aclk); while (alarm_event !== 1'b1);
        n = 0;
        do @(posedge aclk) n++; while (alarm_event !== 1'b1);
        check("alarm spacing", n, 2 * TPH);
        rchk(`RTCAL_OFS_ALARM_CFG, 16'hC4FE, 16'hFFFF);
        wr(`RTCAL_OFS_ALARM_CFG, 16'h0000, 4'h3);
    endtask
    task automatic give_verdict();
        $display("checks %0d errors %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        por_n <= 1'b1;
        s_reset_map();
        s_locks();
        s_calendar();
        s_half_flag();
        s_clock_pin(16'hA000, 32'h0);
        s_clock_pin(16'hA400, 32'h1);
        s_alarm();
        give_verdict();
    end
endmodule
